// *** rtl/pfs_pin_select.sv ***
// Pin function select for ports A and B: select registers and pin routing.
// Assumes pad logic drives pins from gpio_sel/pad_oe and peripherals on clk.
//
// Notes on behaviour
// - Port A bit 3 goes to over-voltage input three on code 01, else GPIO.
// - Port A bit 7 is GPIO on 00/11, timer clock out on 01, op-amp inv 0 on 10.
// - Port A bit 6 goes to the op-amp non-inverting input on 01, else GPIO.
// - Port A bit 5 goes to over-voltage input five on 01, else GPIO.
// - Port A bit 4 goes to over-voltage input four on 01, else GPIO.
// - Port B bit 3 is analog channel 3 on 01, else GPIO with timer 1 clock in.
// - Port B bit 2 is GPIO plus timer 0 clock, phase, channel 2 or vref.
// - Port B bit 0 is GPIO on 00/11, op-amp inv 1 on 01, channel 0 on 10.
// - Port B bit 7 is GPIO, timer 2 out, serial clock or channel 7.
// - Port B bit 6 is GPIO on 00/11, taken from GPIO with nothing routed on 01, channel 6 on 10.
// - Port B bit 5 is timer 1 inverted out, channel 5, else GPIO plus capture.
// - Port B bit 4 on code 00 is GPIO with timer 2 clock and interrupt zero.
// - Serial data input follows its own source field, not the pin fields.
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_select (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pad inputs, asynchronous to clk
    input wire logic [7:0] pad_a_in,
    input wire logic [7:0] pad_b_in,
    input wire logic pad_c2_in,
    // Peripheral outputs to be routed out
    input var pfs_pkg::pfs_dout_s periph_out,
    // Pad drive for peripheral-owned pins
    output logic [7:0] gpio_sel_a,
    output logic [7:0] gpio_sel_b,
    output logic [7:0] pad_a_out,
    output logic [7:0] pad_a_oe,
    output logic [7:0] pad_b_out,
    output logic [7:0] pad_b_oe,
    // Peripheral-side connections
    output pfs_pkg::pfs_analog_s analog_sel,
    output pfs_pkg::pfs_din_s periph_in
);

    pfs_pkg::pfs_bus_req_s req;
    logic [pfs_pkg::NUM_REGS*8-1:0] regs_flat;
    logic [7:0] pa_low;
    logic [7:0] pa_high;
    logic [7:0] pb_low;
    logic [7:0] pb_high;
    logic [7:0] src_sel;
    logic [16:0] sync1_ff;
    logic [16:0] sync2_ff;
    logic [16:0] sync3_ff;
    logic [16:0] pin_ff;
    logic [7:0] pin_a;
    logic [7:0] pin_b;
    logic pin_c2;
    logic [7:0] gpio_sel_a_ff;
    logic [7:0] gpio_sel_b_ff;
    logic [7:0] pad_a_out_ff;
    logic [7:0] pad_a_oe_ff;
    logic [7:0] pad_b_out_ff;
    logic [7:0] pad_b_oe_ff;
    logic [7:0] nxt_gpio_sel_a;
    logic [7:0] nxt_gpio_sel_b;
    logic [7:0] nxt_pad_a_out;
    logic [7:0] nxt_pad_a_oe;
    logic [7:0] nxt_pad_b_out;
    logic [7:0] nxt_pad_b_oe;
    pfs_pkg::pfs_analog_s analog_ff;
    pfs_pkg::pfs_analog_s nxt_analog;
    pfs_pkg::pfs_din_s din_ff;
    pfs_pkg::pfs_din_s nxt_din;

    // Two-bit field of a select register
    function automatic logic [1:0] field(input logic [7:0] r, input int lsb);
        field = r[lsb +: 2];
    endfunction : field

    // Bundle the port signals
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;
    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;

    // Select registers plus the serial source field
    pfs_regfile #(
        .NREG(pfs_pkg::NUM_REGS),
        .W(8),
        .AW(8),
        .MASK({pfs_pkg::MASK_SRC_SEL, pfs_pkg::MASK_SELECT,
               pfs_pkg::MASK_SELECT, pfs_pkg::MASK_SELECT,
               pfs_pkg::MASK_SELECT}),
        .RST(pfs_pkg::RST_SELECT)
    ) u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .wr(req.wr),
        .rd(req.rd),
        .addr(req.addr),
        .wdata(req.wdata),
        .rdata_ff(reg_rdata),
        .regs_flat(regs_flat)
    );

    // Unpack the stored registers by offset
    assign pa_low = regs_flat[int'(pfs_pkg::OFS_PA_LOW)*8 +: 8];
    assign pa_high = regs_flat[int'(pfs_pkg::OFS_PA_HIGH)*8 +: 8];
    assign pb_low = regs_flat[int'(pfs_pkg::OFS_PB_LOW)*8 +: 8];
    assign pb_high = regs_flat[int'(pfs_pkg::OFS_PB_HIGH)*8 +: 8];
    assign src_sel = regs_flat[int'(pfs_pkg::OFS_SRC_SEL)*8 +: 8];

    // Three-stage pad synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else if (clk_en) begin
            sync1_ff <= {pad_c2_in, pad_b_in, pad_a_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Accept a pin change only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_ff <= '0;
        end else if (clk_en) begin
            pin_ff <= (sync2_ff & ~(sync2_ff ^ sync3_ff))
                    | (pin_ff & (sync2_ff ^ sync3_ff));
        end
    end

    assign pin_a = pin_ff[7:0];
    assign pin_b = pin_ff[15:8];
    assign pin_c2 = pin_ff[16];

    // Port A routing
    always_comb begin
        nxt_gpio_sel_a = 8'hFF;
        nxt_pad_a_out = 8'h00;
        nxt_pad_a_oe = 8'h00;
        nxt_analog = '0;
        // Pins 0 to 2 keep GPIO whatever their codes say
        nxt_gpio_sel_a[2:0] = 3'h7;
        if (field(pa_low, pfs_pkg::FLD_PA3) == pfs_pkg::CODE_01) begin
            nxt_gpio_sel_a[3] = 1'b0;
            nxt_analog.overvoltage_in_three = 1'b1;
        end
        if (field(pa_high, pfs_pkg::FLD_PA4) == pfs_pkg::CODE_01) begin
            nxt_gpio_sel_a[4] = 1'b0;
            nxt_analog.overvoltage_in_four = 1'b1;
        end
        if (field(pa_high, pfs_pkg::FLD_PA5) == pfs_pkg::CODE_01) begin
            nxt_gpio_sel_a[5] = 1'b0;
            nxt_analog.overvoltage_in_five = 1'b1;
        end
        if (field(pa_high, pfs_pkg::FLD_PA6) == pfs_pkg::CODE_01) begin
            nxt_gpio_sel_a[6] = 1'b0;
            nxt_analog.opamp_noninv_in = 1'b1;
        end
        unique case (field(pa_high, pfs_pkg::FLD_PA7))
            pfs_pkg::CODE_01: begin
                nxt_gpio_sel_a[7] = 1'b0;
                nxt_pad_a_out[7] = periph_out.timer_clock_out;
                nxt_pad_a_oe[7] = 1'b1;
            end
            pfs_pkg::CODE_10: begin
                nxt_gpio_sel_a[7] = 1'b0;
                nxt_analog.opamp_inv_in_zero = 1'b1;
            end
            pfs_pkg::CODE_00, pfs_pkg::CODE_11: begin
                nxt_gpio_sel_a[7] = 1'b1;
            end
        endcase

        // Port B, low register
        nxt_gpio_sel_b = 8'hFF;
        nxt_pad_b_out = 8'h00;
        nxt_pad_b_oe = 8'h00;
        unique case (field(pb_low, pfs_pkg::FLD_PB0))
            pfs_pkg::CODE_01: begin
                nxt_gpio_sel_b[0] = 1'b0;
                nxt_analog.opamp_inv_in_one = 1'b1;
            end
            pfs_pkg::CODE_10: begin
                nxt_gpio_sel_b[0] = 1'b0;
                nxt_analog.analog_ch_zero = 1'b1;
            end
            pfs_pkg::CODE_00, pfs_pkg::CODE_11: begin
                nxt_gpio_sel_b[0] = 1'b1;
            end
        endcase
        unique case (field(pb_low, pfs_pkg::FLD_PB2))
            pfs_pkg::CODE_01: begin
                nxt_gpio_sel_b[2] = 1'b0;
                nxt_analog.phase_in = 1'b1;
            end
            pfs_pkg::CODE_10: begin
                nxt_gpio_sel_b[2] = 1'b0;
                nxt_analog.analog_ch_two = 1'b1;
            end
            pfs_pkg::CODE_11: begin
                nxt_gpio_sel_b[2] = 1'b0;
                nxt_analog.vref_pin = 1'b1;
            end
            pfs_pkg::CODE_00: begin
                nxt_gpio_sel_b[2] = 1'b1;
            end
        endcase
        if (field(pb_low, pfs_pkg::FLD_PB3) == pfs_pkg::CODE_01) begin
            nxt_gpio_sel_b[3] = 1'b0;
            nxt_analog.analog_ch_three = 1'b1;
        end

        // Port B, high register
        unique case (field(pb_high, pfs_pkg::FLD_PB5))
            pfs_pkg::CODE_01: begin
                nxt_gpio_sel_b[5] = 1'b0;
                nxt_pad_b_out[5] = periph_out.compare_timer1_out_inverted;
                nxt_pad_b_oe[5] = 1'b1;
            end
            pfs_pkg::CODE_10: begin
                nxt_gpio_sel_b[5] = 1'b0;
                nxt_analog.analog_ch_five = 1'b1;
            end
            pfs_pkg::CODE_00, pfs_pkg::CODE_11: begin
                nxt_gpio_sel_b[5] = 1'b1;
            end
        endcase
        unique case (field(pb_high, pfs_pkg::FLD_PB6))
            pfs_pkg::CODE_01: begin
                nxt_gpio_sel_b[6] = 1'b0;
            end
            pfs_pkg::CODE_10: begin
                nxt_gpio_sel_b[6] = 1'b0;
                nxt_analog.analog_ch_six = 1'b1;
            end
            pfs_pkg::CODE_00, pfs_pkg::CODE_11: begin
                nxt_gpio_sel_b[6] = 1'b1;
            end
        endcase
        unique case (field(pb_high, pfs_pkg::FLD_PB7))
            pfs_pkg::CODE_01: begin
                nxt_gpio_sel_b[7] = 1'b0;
                nxt_pad_b_out[7] = periph_out.compare_timer2_out;
                nxt_pad_b_oe[7] = 1'b1;
            end
            pfs_pkg::CODE_10: begin
                // Serial clock may be bidirectional; its block owns the enable
                nxt_gpio_sel_b[7] = 1'b0;
                nxt_pad_b_out[7] = periph_out.serial_clock_out;
                nxt_pad_b_oe[7] = periph_out.serial_clock_oe;
            end
            pfs_pkg::CODE_11: begin
                nxt_gpio_sel_b[7] = 1'b0;
                nxt_analog.analog_ch_seven = 1'b1;
            end
            pfs_pkg::CODE_00: begin
                nxt_gpio_sel_b[7] = 1'b1;
            end
        endcase
    end

    // Shared digital inputs other than serial data; zero whenever the pin is given elsewhere
    always_comb begin
        nxt_din = '0;
        if (field(pb_low, pfs_pkg::FLD_PB2) == pfs_pkg::CODE_00) begin
            nxt_din.compare_timer0_clock_in = pin_b[2];
        end
        if (field(pb_low, pfs_pkg::FLD_PB3) != pfs_pkg::CODE_01) begin
            nxt_din.compare_timer1_clock_in = pin_b[3];
        end
        if (field(pb_high, pfs_pkg::FLD_PB4) == pfs_pkg::CODE_00) begin
            nxt_din.compare_timer2_clock_in = pin_b[4];
            nxt_din.ext_interrupt_zero = pin_b[4];
        end
        if (field(pb_high, pfs_pkg::FLD_PB5) == pfs_pkg::CODE_00 ||
            field(pb_high, pfs_pkg::FLD_PB5) == pfs_pkg::CODE_11) begin
            nxt_din.periodic_timer_capture_in = pin_b[5];
            nxt_din.ext_interrupt_one = pin_b[5];
        end
        // Source field alone picks the serial data pin
        unique case (field(src_sel, pfs_pkg::FLD_SRC))
            pfs_pkg::SRC_PA2_A, pfs_pkg::SRC_PA2_B: begin
                nxt_din.serial_data_in = pin_a[pfs_pkg::PIN_A2];
            end
            pfs_pkg::SRC_PC2: begin
                nxt_din.serial_data_in = pin_c2;
            end
            pfs_pkg::SRC_PB6: begin
                nxt_din.serial_data_in = pin_b[pfs_pkg::PIN_B6];
            end
        endcase
    end

    // Pad-side outputs registered; one cycle behind a register write
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gpio_sel_a_ff <= 8'hFF;
            gpio_sel_b_ff <= 8'hFF;
            pad_a_out_ff <= 8'h00;
            pad_a_oe_ff <= 8'h00;
            pad_b_out_ff <= 8'h00;
            pad_b_oe_ff <= 8'h00;
        end else if (clk_en) begin
            gpio_sel_a_ff <= nxt_gpio_sel_a;
            gpio_sel_b_ff <= nxt_gpio_sel_b;
            pad_a_out_ff <= nxt_pad_a_out;
            pad_a_oe_ff <= nxt_pad_a_oe;
            pad_b_out_ff <= nxt_pad_b_out;
            pad_b_oe_ff <= nxt_pad_b_oe;
        end
    end

    // Peripheral-side outputs registered
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            analog_ff <= '0;
            din_ff <= '0;
        end else if (clk_en) begin
            analog_ff <= nxt_analog;
            din_ff <= nxt_din;
        end
    end

    assign gpio_sel_a = gpio_sel_a_ff;
    assign gpio_sel_b = gpio_sel_b_ff;
    assign pad_a_out = pad_a_out_ff;
    assign pad_a_oe = pad_a_oe_ff;
    assign pad_b_out = pad_b_out_ff;
    assign pad_b_oe = pad_b_oe_ff;
    assign analog_sel = analog_ff;
    assign periph_in = din_ff;

endmodule : pfs_pin_select
`default_nettype wire

// *** common/pfs_pkg.sv ***
// Shared constants and carriers for the port A/B pin function select block.
// Assumes a single 100 MHz clock and an 8-bit plain register port.
package pfs_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 5;

    // Register offsets (index on the plain port)
    localparam logic [7:0] OFS_PA_LOW = 8'h00;
    localparam logic [7:0] OFS_PA_HIGH = 8'h01;
    localparam logic [7:0] OFS_PB_LOW = 8'h02;
    localparam logic [7:0] OFS_PB_HIGH = 8'h03;
    localparam logic [7:0] OFS_SRC_SEL = 8'h04;

    // Reset values
    localparam logic [7:0] RST_SELECT = 8'h00;

    // Implemented bits per register, unimplemented bits read as zero
    localparam logic [7:0] MASK_SELECT = 8'hFF;
    localparam logic [7:0] MASK_SRC_SEL = 8'h30;

    // Field positions inside the select registers
    localparam int FLD_PA3 = 6;
    localparam int FLD_PA7 = 6;
    localparam int FLD_PA6 = 4;
    localparam int FLD_PA5 = 2;
    localparam int FLD_PA4 = 0;
    localparam int FLD_PB3 = 6;
    localparam int FLD_PB2 = 4;
    localparam int FLD_PB0 = 0;
    localparam int FLD_PB7 = 6;
    localparam int FLD_PB6 = 4;
    localparam int FLD_PB5 = 2;
    localparam int FLD_PB4 = 0;
    localparam int FLD_SRC = 4;

    // Field codes
    localparam logic [1:0] CODE_00 = 2'h0;
    localparam logic [1:0] CODE_01 = 2'h1;
    localparam logic [1:0] CODE_10 = 2'h2;
    localparam logic [1:0] CODE_11 = 2'h3;

    // Serial data input source codes
    localparam logic [1:0] SRC_PA2_A = 2'h0;
    localparam logic [1:0] SRC_PA2_B = 2'h1;
    localparam logic [1:0] SRC_PC2 = 2'h2;
    localparam logic [1:0] SRC_PB6 = 2'h3;

    // Pin bit positions
    localparam int PIN_A2 = 2;
    localparam int PIN_B6 = 6;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pfs_bus_req_s;

    // Analog function connections
    typedef struct packed {
        logic overvoltage_in_three;
        logic overvoltage_in_four;
        logic overvoltage_in_five;
        logic opamp_inv_in_zero;
        logic opamp_inv_in_one;
        logic opamp_noninv_in;
        logic analog_ch_zero;
        logic analog_ch_two;
        logic analog_ch_three;
        logic analog_ch_five;
        logic analog_ch_six;
        logic analog_ch_seven;
        logic vref_pin;
        logic phase_in;
    } pfs_analog_s;

    // Digital inputs handed to peripherals
    typedef struct packed {
        logic ext_interrupt_zero;
        logic ext_interrupt_one;
        logic compare_timer0_clock_in;
        logic compare_timer1_clock_in;
        logic compare_timer2_clock_in;
        logic periodic_timer_capture_in;
        logic serial_data_in;
    } pfs_din_s;

    // Digital outputs offered by peripherals
    typedef struct packed {
        logic timer_clock_out;
        logic compare_timer2_out;
        logic compare_timer1_out_inverted;
        logic serial_clock_out;
        logic serial_clock_oe;
    } pfs_dout_s;

endpackage : pfs_pkg

// *** rtl/pfs_regfile.sv ***
// Small register file for the pin select registers with registered read.
// Assumes one clock, synchronous active-low reset and a one-cycle read port.
`timescale 1ns/10ps
`default_nettype none
module pfs_regfile #(
    parameter int NREG = pfs_pkg::NUM_REGS,
    parameter int W = pfs_pkg::DATA_W,
    parameter int AW = pfs_pkg::ADDR_W,
    parameter logic [NREG*W-1:0] MASK = {NREG*W{1'b1}},
    parameter logic [W-1:0] RST = '0
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Access port
    input wire logic wr,
    input wire logic rd,
    input wire logic [AW-1:0] addr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata_ff,
    // Stored contents, masked
    output logic [NREG*W-1:0] regs_flat
);

    logic [W-1:0] mem_ff [NREG];
    logic [W-1:0] nxt_rdata;

    // One storage word per register, cleared to reset value
    for (genvar g = 0; g < NREG; g++) begin : g_word
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                mem_ff[g] <= RST;
            end else if (clk_en && wr && addr == AW'(g)) begin
                mem_ff[g] <= wdata & MASK[g*W +: W];
            end
        end
        assign regs_flat[g*W +: W] = mem_ff[g];
    end

    // Read mux, unmapped addresses answer zero
    always_comb begin
        nxt_rdata = '0;
        for (int i = 0; i < NREG; i++) begin
            if (rd && addr == AW'(i)) begin
                nxt_rdata = mem_ff[i];
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_ff <= '0;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
        end
    end

endmodule : pfs_regfile
`default_nettype wire

// *** testbench/pfs_pin_select_props.sv ***
// Checker for the pin select routing; keeps its own copy of the four select registers.
// Assumes it is bound to pfs_pin_select and that reset is synchronous.
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_select_props (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Routed signals
    input var pfs_pkg::pfs_dout_s periph_out,
    input wire logic [7:0] gpio_sel_a,
    input wire logic [7:0] pad_a_out,
    input wire logic [7:0] pad_a_oe,
    input wire logic [7:0] pad_b_out,
    input wire logic [7:0] pad_b_oe,
    input var pfs_pkg::pfs_analog_s analog_sel
);
    logic [31:0] sh_ff;
    logic [31:0] pv_ff;
    // Shadow copy; writes freeze with clk_en as in the design, but its reset also waits for clk_en
    always_ff @(posedge clk) begin
        if (!reset_n && clk_en) begin
            sh_ff <= '0;
        end else if (clk_en && reg_wr && reg_addr < 8'h04) begin
            sh_ff[reg_addr[1:0]*8 +: 8] <= reg_wdata;
        end
    end
    // Shadow as it stood one edge earlier
    always_ff @(posedge clk) pv_ff <= sh_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Outputs were updated from the registers at the previous enabled edge
    sequence s_live;
        $past(clk_en) && $past(reset_n);
    endsequence
    a_pa3_ov_route: assert property (s_live |->
        analog_sel.overvoltage_in_three == (pv_ff[7:6] == 2'h1)
        && gpio_sel_a[3] == (pv_ff[7:6] != 2'h1))
        else $error("pa3 route wrong");
    a_pa7_route: assert property (s_live |->
        pad_a_oe[7] == (pv_ff[15:14] == 2'h1)
        && analog_sel.opamp_inv_in_zero == (pv_ff[15:14] == 2'h2)
        && (!pad_a_oe[7] || pad_a_out[7] == $past(periph_out.timer_clock_out)))
        else $error("pa7 route wrong");
    a_pa6_noninv: assert property (s_live |->
        analog_sel.opamp_noninv_in == (pv_ff[13:12] == 2'h1))
        else $error("pa6 route wrong");
    a_pa54_ov_route: assert property (s_live |->
        analog_sel.overvoltage_in_five == (pv_ff[11:10] == 2'h1)
        && analog_sel.overvoltage_in_four == (pv_ff[9:8] == 2'h1))
        else $error("pa5 or pa4 route wrong");
    a_pb3_channel: assert property (s_live |->
        analog_sel.analog_ch_three == (pv_ff[23:22] == 2'h1))
        else $error("pb3 route wrong");
    a_pb2_route: assert property (s_live |->
        analog_sel.phase_in == (pv_ff[21:20] == 2'h1)
        && analog_sel.analog_ch_two == (pv_ff[21:20] == 2'h2)
        && analog_sel.vref_pin == (pv_ff[21:20] == 2'h3))
        else $error("pb2 route wrong");
    a_pb0_route: assert property (s_live |->
        analog_sel.opamp_inv_in_one == (pv_ff[17:16] == 2'h1)
        && analog_sel.analog_ch_zero == (pv_ff[17:16] == 2'h2))
        else $error("pb0 route wrong");
    a_pb7_route: assert property (s_live |->
        analog_sel.analog_ch_seven == (pv_ff[31:30] == 2'h3)
        && pad_b_oe[7] == (pv_ff[31:30] == 2'h1 || (pv_ff[31:30]
        == 2'h2 && $past(periph_out.serial_clock_oe))))
        else $error("pb7 route wrong");
    a_pb65_route: assert property (s_live |->
        analog_sel.analog_ch_six == (pv_ff[29:28] == 2'h2)
        && analog_sel.analog_ch_five == (pv_ff[27:26] == 2'h2)
        && pad_b_oe[5] == (pv_ff[27:26] == 2'h1) && (!pad_b_oe[5] ||
        pad_b_out[5] == $past(periph_out.compare_timer1_out_inverted)))
        else $error("pb6 or pb5 route wrong");
    a_pa_low_gpio: assert property (s_live |->
        gpio_sel_a[2:0] == 3'h7)
        else $error("pa low pins left gpio");
    a_read_answer: assert property (
        clk_en && reg_rd && reg_addr < 8'h04 |=>
        reg_rdata == sh_ff[$past(reg_addr[1:0])*8 +: 8])
        else $error("read data differs from written value");
endmodule : pfs_pin_select_props
bind pfs_pin_select pfs_pin_select_props pfs_pin_select_props_inst (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_out(periph_out), .gpio_sel_a(gpio_sel_a),
    .pad_a_out(pad_a_out), .pad_a_oe(pad_a_oe), .pad_b_out(pad_b_out),
    .pad_b_oe(pad_b_oe), .analog_sel(analog_sel));
`default_nettype wire

// *** testbench/pfs_periph_model.sv ***
// Far side model: peripherals offering outputs and the board at the pads.
// Assumes the bench sets the outside pad levels and the write strobe.
`timescale 1ns/10ps
`default_nettype none
module pfs_periph_model (
    // Clock and bus watch
    input wire logic clk,
    input wire logic reg_wr,
    // Board levels and design pad drive
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    input wire logic [7:0] pad_a_out,
    input wire logic [7:0] pad_a_oe,
    input wire logic [7:0] pad_b_out,
    input wire logic [7:0] pad_b_oe,
    // Towards the design
    output var pfs_pkg::pfs_dout_s periph_out,
    output logic [7:0] pad_a_in,
    output logic [7:0] pad_b_in
);
    logic [4:0] pat_ff = 5'h01;
    // Pad level: design drive wins; inputs only where pins are undriven
    assign pad_a_in = (pad_a_oe & pad_a_out) | (~pad_a_oe & ext_a);
    assign pad_b_in = (pad_b_oe & pad_b_out) | (~pad_b_oe & ext_b);
    // Outputs step through a 5-bit shift pattern every cycle so a stale route cannot pass
    always @(posedge clk) begin
        pat_ff <= {pat_ff[3:0], pat_ff[4] ^ pat_ff[2]};
    end
    // Peripherals held off while a select field is rewritten
    assign periph_out = reg_wr ? 5'h00 : pat_ff;
endmodule : pfs_periph_model
`default_nettype wire

// *** testbench/port_ab_pin_function_select_tb_top.sv ***
// Self-checking bench for the port A/B pin select block.
// Assumes the design and the far side model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module port_ab_pin_function_select_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pad_c2_in = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] ext_a = 8'h00;
    logic [7:0] ext_b = 8'h00;
    logic [7:0] reg_rdata, gpio_sel_a, gpio_sel_b, pad_a_in, pad_b_in;
    logic [7:0] pad_a_out, pad_a_oe, pad_b_out, pad_b_oe;
    logic [7:0] shd [5];
    pfs_pkg::pfs_dout_s periph_out;
    pfs_pkg::pfs_analog_s analog_sel;
    pfs_pkg::pfs_din_s periph_in;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    // Bench nets carry the port names, so ports connect by name
    pfs_pin_select pfs_pin_select_inst (.*);
    pfs_periph_model pfs_periph_model_inst (.*);
    // 100 MHz clock
    always #5 clk = ~clk;
    // Hang guard, well above the roughly 1570 cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a < 8'h05) shd[a] = a == 8'h04 ? d & pfs_pkg::MASK_SRC_SEL : d;
    endtask : wr
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask : rd_check
    // Field of a register equals a code
    function automatic logic f(input logic [7:0] r, input int lsb,
                               input logic [1:0] c);
        return r[lsb+:2] == c;
    endfunction : f
    // Codes 00 and 11 leave the pin with general I/O
    function automatic logic gp(input logic [7:0] r, input int lsb);
        return !f(r, lsb, 2'h1) && !f(r, lsb, 2'h2);
    endfunction : gp
    function automatic logic [13:0] exp_analog();
        return {f(shd[0], 6, 2'h1), f(shd[1], 0, 2'h1), f(shd[1], 2, 2'h1),
            f(shd[1], 6, 2'h2), f(shd[2], 0, 2'h1), f(shd[1], 4, 2'h1),
            f(shd[2], 0, 2'h2), f(shd[2], 4, 2'h2), f(shd[2], 6, 2'h1),
            f(shd[3], 2, 2'h2), f(shd[3], 4, 2'h2), f(shd[3], 6, 2'h3),
            f(shd[2], 4, 2'h3), f(shd[2], 4, 2'h1)};
    endfunction : exp_analog
    function automatic logic [7:0] exp_gpio_a();
        return {gp(shd[1], 6), !f(shd[1], 4, 2'h1), !f(shd[1], 2, 2'h1),
            !f(shd[1], 0, 2'h1), !f(shd[0], 6, 2'h1), 3'h7};
    endfunction : exp_gpio_a
    function automatic logic [7:0] exp_gpio_b();
        return {f(shd[3], 6, 2'h0), gp(shd[3], 4), gp(shd[3], 2), 1'b1,
            !f(shd[2], 6, 2'h1), f(shd[2], 4, 2'h0), 1'b1, gp(shd[2], 0)};
    endfunction : exp_gpio_b
    // Digital inputs seen by peripherals; serial data by its own source
    function automatic logic [6:0] exp_din();
        logic i0, i1;
        logic [3:0] sd;
        i0 = f(shd[3], 0, 2'h0) & ext_b[4];
        i1 = gp(shd[3], 2) & ext_b[5];
        sd = {ext_b[6], pad_c2_in, ext_a[2], ext_a[2]};
        return {i0, i1, f(shd[2], 4, 2'h0) & ext_b[2],
            !f(shd[2], 6, 2'h1) & ext_b[3], i0, i1, sd[shd[4][5:4]]};
    endfunction : exp_din
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    // Main sequence: reset, all codes, random settings, freeze, reset again
    initial begin
        logic [7:0] d;
        void'($urandom(14862));
        for (int i = 0; i < 5; i++) shd[i] = 8'h00;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check("gpio_sel_a", gpio_sel_a, 8'hFF);
        check("analog_sel", analog_sel, 16'h0000);
        for (int a = 0; a < 6; a++) rd_check(a[7:0], 8'h00);
        for (int it = 0; it < 64; it++) begin
            for (int a = 0; a < 6; a++) begin
                d = it < 4 ? {4{it[1:0]}} : 8'($urandom);
                wr(a[7:0], d);
            end
            ext_a <= 8'($urandom);
            ext_b <= 8'($urandom);
            pad_c2_in <= 1'($urandom);
            for (int a = 0; a < 6; a++) begin
                rd_check(a[7:0], a < 5 ? shd[a] : 8'h00);
            end
            check("analog_sel", analog_sel, exp_analog());
            check("gpio_sel_a", gpio_sel_a, exp_gpio_a());
            check("gpio_sel_b", gpio_sel_b, exp_gpio_b());
            check("periph_in", periph_in, exp_din());
            check("pad_a_oe", pad_a_oe, {f(shd[1], 6, 2'h1), 7'h00});
        end
        clk_en <= 1'b0;
        d = shd[0];
        wr(8'h00, ~d);
        shd[0] = d;
        clk_en <= 1'b1;
        rd_check(8'h00, d);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 5; a++) rd_check(a[7:0], 8'h00);
        summarize();
    end
endmodule : port_ab_pin_function_select_tb_top
`default_nettype wire
